/* logic/bwm_consts.svh */
// Constants for the I/O bandwidth monitor counter bank.
`ifndef BWM_CONSTS_SVH
`define BWM_CONSTS_SVH

// Tag space and field geometry.
`define BWM_TAG_COUNT 32
`define BWM_TAG_W 5
`define BWM_CNT_W 62
`define BWM_INC_W 16
`define BWM_DATA_W 64
`define BWM_UNAVAIL_BIT 63
`define BWM_OVF_BIT 62

// Register space layout, relative to the register base address.
`define BWM_ADDR_W 13
`define BWM_PAGE_SHIFT 12
`define BWM_PAGE_BYTES 4096
`define BWM_WORD_BYTES 8
`define BWM_BLOCK_COUNT 2
`define BWM_TOT_OFFSET 12'h000
`define BWM_TOT_CLUMP 16
`define BWM_MISS_OFFSET 12'h800
`define BWM_MISS_CLUMP 16
`define BWM_INDEX_VERSION 1

// Reset values.
`define BWM_CNT_RESET 62'h0
`define BWM_OVF_RESET 32'h0

`endif

/* logic/bwm_pkg.sv */
// Types shared by the I/O bandwidth monitor counter bank.
`include "bwm_consts.svh"

package bwm_pkg;

    typedef enum logic [1:0] {
        BWM_INIT,
        BWM_IDLE,
        BWM_UPD,
        BWM_RESP
    } bwm_state_e;

    typedef enum logic [1:0] {
        BWM_KIND_NONE,
        BWM_KIND_TOT,
        BWM_KIND_MISS
    } bwm_kind_e;

    typedef struct packed {
        logic write;
        logic [`BWM_ADDR_W-1:0] addr;
        logic [`BWM_DATA_W-1:0] wdata;
    } bwm_req_s;

    typedef struct packed {
        logic [`BWM_TAG_W-1:0] tag;
        logic [`BWM_INC_W-1:0] bytes;
        logic miss;
    } bwm_ev_s;

endpackage : bwm_pkg

/* logic/bwm_counter_ram.sv */
// One-write, one-read counter memory with registered read data.
`timescale 1ns/1ps

module bwm_counter_ram #(
    parameter int W = 62,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // Clock.
    input wire logic clk_sys,
    // Write port.
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    // Read port.
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data_q
);

    logic [W-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // Read data holds between reads so the caller may use it a cycle later.
    always_ff @(posedge clk_sys) begin
        if (rd_en) begin
            rd_data_q <= mem_q[rd_addr];
        end
    end

endmodule : bwm_counter_ram

/* logic/bwm_monitor_bank.sv */
// Per-tag total and miss I/O bandwidth counter bank for one management domain.
//
// Functional notes
// R1 - Bit 63 shows tag unavailable or unmonitored.
// R2 - Bit 62 of total word flags overflow.
// R3 - Bit 62 of miss word flags overflow.
// R4 - Reading a word clears its overflow flag.
// R5 - Total count sits in bits 61:0.
// R6 - Miss count sits in bits 61:0.
// R7 - Total counter counts all traffic per tag.
// R8 - Miss counter counts near-cache miss traffic.
// R9 - Tags run zero to maximum, one word each.
// R10 - Total word address from clump, offset, stride.
// R11 - Miss word address from clump, offset, stride.
// R12 - Total words stay inside reported blocks.
// R13 - Miss words stay inside reported blocks.
// R14 - Software uses mapping only for version one.
// R15 - One bank per domain, own traffic only.
// R16 - Counts wrap to zero and flag overflow.
// R17 - Writes and reserved offsets are ignored.
`timescale 1ns/1ps
`include "bwm_consts.svh"

module bwm_monitor_bank
    import bwm_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Register access.
    input wire logic req_valid,
    output logic req_ready,
    input wire bwm_req_s req,
    output logic rsp_valid_q,
    output logic [`BWM_DATA_W-1:0] rsp_data_q,
    // Traffic events of this domain.
    input wire logic ev_valid,
    output logic ev_ready,
    input wire bwm_ev_s ev,
    // Monitoring status per tag.
    input wire logic [`BWM_TAG_COUNT-1:0] tag_monitored
);

    localparam logic [`BWM_TAG_W-1:0] LAST_TAG = `BWM_TAG_W'(`BWM_TAG_COUNT - 1);

    bwm_state_e state_q;
    bwm_state_e state_d;
    logic [`BWM_TAG_W-1:0] init_cnt_q;
    bwm_kind_e rd_kind_q;
    logic [`BWM_TAG_W-1:0] rd_tag_q;
    bwm_ev_s upd_q;
    logic [`BWM_TAG_COUNT-1:0] ovf_tot_q;
    logic [`BWM_TAG_COUNT-1:0] ovf_miss_q;

    bwm_kind_e dec_kind;
    logic [`BWM_TAG_W-1:0] dec_tag;
    logic take_req;
    logic take_ev;

    logic tot_wr_en;
    logic miss_wr_en;
    logic [`BWM_TAG_W-1:0] wr_tag;
    logic [`BWM_CNT_W-1:0] tot_wr_data;
    logic [`BWM_CNT_W-1:0] miss_wr_data;
    logic tot_rd_en;
    logic miss_rd_en;
    logic [`BWM_TAG_W-1:0] rd_tag;
    logic [`BWM_CNT_W-1:0] tot_rdata;
    logic [`BWM_CNT_W-1:0] miss_rdata;
    logic [`BWM_CNT_W:0] tot_sum;
    logic [`BWM_CNT_W:0] miss_sum;
    logic tot_wrap;
    logic miss_wrap;
    logic [`BWM_TAG_COUNT-1:0] ovf_tot_clr;
    logic [`BWM_TAG_COUNT-1:0] ovf_tot_set;
    logic [`BWM_TAG_COUNT-1:0] ovf_miss_clr;
    logic [`BWM_TAG_COUNT-1:0] ovf_miss_set;
    logic [`BWM_DATA_W-1:0] rsp_data_d;

    // Maps an offset inside one clump region to a tag; anything off the
    // stride, outside the clump or past the last tag is no word at all.
    function automatic logic map_word(
        input logic [`BWM_ADDR_W-1:0] a,
        input int unsigned region_off,
        input int unsigned clump,
        output logic [`BWM_TAG_W-1:0] tag
    );
        int unsigned pg;
        int unsigned off;
        int unsigned idx;
        pg = int'(a >> `BWM_PAGE_SHIFT);
        off = int'(a[`BWM_PAGE_SHIFT-1:0]);
        idx = pg * clump + (off - region_off) / `BWM_WORD_BYTES;
        tag = idx[`BWM_TAG_W-1:0];
        map_word = (off >= region_off) && (off < region_off + clump * `BWM_WORD_BYTES)
            && (off % `BWM_WORD_BYTES == 0) && (pg < `BWM_BLOCK_COUNT)
            && (idx < `BWM_TAG_COUNT);
    endfunction : map_word

    // Software only relies on this layout while the reported indexing version
    // is one; the layout here is fixed, so a change of layout needs a new version.
    always_comb begin
        logic [`BWM_TAG_W-1:0] t_tag;
        logic [`BWM_TAG_W-1:0] m_tag;
        t_tag = '0;
        m_tag = '0;
        dec_kind = BWM_KIND_NONE;
        dec_tag = '0;
        if (!req.write) begin // [R17]
            if (map_word(req.addr, `BWM_TOT_OFFSET, `BWM_TOT_CLUMP, t_tag)) begin // [R10] [R12]
                dec_kind = BWM_KIND_TOT;
                dec_tag = t_tag;
            end else if (map_word(req.addr, `BWM_MISS_OFFSET, `BWM_MISS_CLUMP, m_tag)) begin // [R11] [R13]
                dec_kind = BWM_KIND_MISS;
                dec_tag = m_tag;
            end
        end
    end

    // Register access wins over traffic; an event waits as long as any access request is pending.
    assign req_ready = (state_q == BWM_IDLE);
    assign ev_ready = (state_q == BWM_IDLE) && !req_valid;
    assign take_req = req_ready && req_valid;
    assign take_ev = ev_ready && ev_valid;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BWM_INIT: begin
                if (init_cnt_q == LAST_TAG) begin
                    state_d = BWM_IDLE;
                end
            end
            BWM_IDLE: begin
                if (take_req) begin
                    state_d = BWM_RESP;
                end else if (take_ev) begin
                    state_d = BWM_UPD;
                end
            end
            BWM_UPD: state_d = BWM_IDLE;
            BWM_RESP: state_d = BWM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= BWM_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // The memories have no reset of their own, so every word is swept to zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            init_cnt_q <= '0;
        end else if (state_q == BWM_INIT) begin
            init_cnt_q <= init_cnt_q + 1'b1; // [R9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_kind_q <= BWM_KIND_NONE;
            rd_tag_q <= '0;
        end else if (take_req) begin
            rd_kind_q <= dec_kind;
            rd_tag_q <= dec_tag;
        end
    end

    // Only this domain's events arrive here; each domain has its own bank.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            upd_q <= '0;
        end else if (take_ev) begin
            upd_q <= ev; // [R15]
        end
    end

    assign rd_tag = req_valid ? dec_tag : ev.tag;
    assign tot_rd_en = take_req ? (dec_kind == BWM_KIND_TOT) : take_ev;
    assign miss_rd_en = take_req ? (dec_kind == BWM_KIND_MISS) : take_ev;

    // Every event is near-cache traffic; misses also count in the miss counter.
    assign tot_sum = {1'b0, tot_rdata} + {{(`BWM_CNT_W + 1 - `BWM_INC_W){1'b0}}, upd_q.bytes}; // [R7]
    assign miss_sum = {1'b0, miss_rdata} + {{(`BWM_CNT_W + 1 - `BWM_INC_W){1'b0}}, upd_q.bytes}; // [R8]
    assign tot_wrap = (state_q == BWM_UPD) && tot_sum[`BWM_CNT_W]; // [R16]
    assign miss_wrap = (state_q == BWM_UPD) && upd_q.miss && miss_sum[`BWM_CNT_W]; // [R16]

    assign tot_wr_en = (state_q == BWM_INIT) || (state_q == BWM_UPD);
    assign miss_wr_en = (state_q == BWM_INIT) || ((state_q == BWM_UPD) && upd_q.miss);
    assign wr_tag = (state_q == BWM_INIT) ? init_cnt_q : upd_q.tag;
    assign tot_wr_data = (state_q == BWM_INIT) ? `BWM_CNT_RESET : tot_sum[`BWM_CNT_W-1:0]; // [R5]
    assign miss_wr_data = (state_q == BWM_INIT) ? `BWM_CNT_RESET : miss_sum[`BWM_CNT_W-1:0]; // [R6]

    bwm_counter_ram #(
        .W(`BWM_CNT_W),
        .DEPTH(`BWM_TAG_COUNT),
        .AW(`BWM_TAG_W)
    ) u_tot_ram (
        .clk_sys(clk_sys),
        .wr_en(tot_wr_en),
        .wr_addr(wr_tag),
        .wr_data(tot_wr_data),
        .rd_en(tot_rd_en),
        .rd_addr(rd_tag),
        .rd_data_q(tot_rdata)
    );

    bwm_counter_ram #(
        .W(`BWM_CNT_W),
        .DEPTH(`BWM_TAG_COUNT),
        .AW(`BWM_TAG_W)
    ) u_miss_ram (
        .clk_sys(clk_sys),
        .wr_en(miss_wr_en),
        .wr_addr(wr_tag),
        .wr_data(miss_wr_data),
        .rd_en(miss_rd_en),
        .rd_addr(rd_tag),
        .rd_data_q(miss_rdata)
    );

    // A wrap in the same cycle as a clearing read keeps the flag set.
    always_comb begin
        ovf_tot_clr = '0;
        ovf_tot_set = '0;
        ovf_miss_clr = '0;
        ovf_miss_set = '0;
        if (state_q == BWM_RESP && rd_kind_q == BWM_KIND_TOT) begin
            ovf_tot_clr[rd_tag_q] = 1'b1; // [R4]
        end
        if (state_q == BWM_RESP && rd_kind_q == BWM_KIND_MISS) begin
            ovf_miss_clr[rd_tag_q] = 1'b1; // [R4]
        end
        if (tot_wrap) begin
            ovf_tot_set[upd_q.tag] = 1'b1; // [R2]
        end
        if (miss_wrap) begin
            ovf_miss_set[upd_q.tag] = 1'b1; // [R3]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ovf_tot_q <= `BWM_OVF_RESET;
        end else begin
            ovf_tot_q <= (ovf_tot_q & ~ovf_tot_clr) | ovf_tot_set;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ovf_miss_q <= `BWM_OVF_RESET;
        end else begin
            ovf_miss_q <= (ovf_miss_q & ~ovf_miss_clr) | ovf_miss_set;
        end
    end

    // The count is shown even while the tag is unavailable; software drops it.
    always_comb begin
        rsp_data_d = '0;
        unique case (rd_kind_q)
            BWM_KIND_TOT: rsp_data_d = {~tag_monitored[rd_tag_q], ovf_tot_q[rd_tag_q], tot_rdata}; // [R1] [R2] [R5]
            BWM_KIND_MISS: rsp_data_d = {~tag_monitored[rd_tag_q], ovf_miss_q[rd_tag_q], miss_rdata}; // [R1] [R3] [R6]
            BWM_KIND_NONE: rsp_data_d = '0; // [R17]
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= '0;
        end else begin
            rsp_valid_q <= (state_q == BWM_RESP);
            if (state_q == BWM_RESP) begin
                rsp_data_q <= rsp_data_d;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_unavail_flag: assert property ( // [R1]
        (state_q == BWM_RESP && rd_kind_q != BWM_KIND_NONE)
        |=> rsp_data_q[`BWM_UNAVAIL_BIT] == !$past(tag_monitored[rd_tag_q]))
        else $error("Unavailable bit does not follow the monitoring status.");

    a_total_ovf_set: assert property ( // [R2]
        tot_wrap |=> ovf_tot_q[$past(upd_q.tag)])
        else $error("Total counter wrapped without raising its overflow flag.");

    a_miss_ovf_set: assert property ( // [R3]
        miss_wrap |=> ovf_miss_q[$past(upd_q.tag)])
        else $error("Miss counter wrapped without raising its overflow flag.");

    a_ovf_read_clear: assert property ( // [R4]
        (state_q == BWM_RESP && rd_kind_q == BWM_KIND_TOT)
        |=> rsp_data_q[`BWM_OVF_BIT] == $past(ovf_tot_q[rd_tag_q]) && !ovf_tot_q[$past(rd_tag_q)])
        else $error("Reading a total word did not report and clear its overflow flag.");

    a_total_count_field: assert property ( // [R5]
        (state_q == BWM_RESP && rd_kind_q == BWM_KIND_TOT)
        |=> rsp_data_q[`BWM_CNT_W-1:0] == $past(tot_rdata))
        else $error("Total count field differs from the stored count.");

    a_miss_count_step: assert property ( // [R8]
        (state_q == BWM_UPD && upd_q.miss)
        |-> miss_wr_en && miss_wr_data == miss_rdata + `BWM_CNT_W'(upd_q.bytes))
        else $error("Miss event did not add its bytes to the miss counter.");

    a_total_no_miss_skip: assert property ( // [R7]
        (state_q == BWM_UPD && !upd_q.miss) |-> tot_wr_en && !miss_wr_en)
        else $error("Hit traffic must count in the total counter only.");

    a_wrap_to_zero: assert property ( // [R16]
        (state_q == BWM_UPD && tot_rdata == {`BWM_CNT_W{1'b1}} && upd_q.bytes == `BWM_INC_W'(1))
        |-> tot_wr_data == `BWM_CNT_RESET)
        else $error("Total count did not wrap to zero at its maximum.");

    a_write_ignored: assert property ( // [R17]
        (take_req && req.write)
        |=> $stable(ovf_tot_q) && $stable(ovf_miss_q) ##1 rsp_valid_q && rsp_data_q == '0)
        else $error("A write changed state or returned data.");

    a_resp_latency: assert property (
        take_req |=> !req_ready && !rsp_valid_q ##1 rsp_valid_q && req_ready)
        else $error("Register access answer did not come two cycles after the request.");

endmodule : bwm_monitor_bank

/* tb/tb_top.sv */
// Self-checking bench for the I/O bandwidth monitor counter bank.
`timescale 1ns/1ps
`include "bwm_consts.svh"

module tb_top
    import bwm_pkg::*;
;
    logic clk_sys;
    logic rst;
    logic req_valid;
    bwm_req_s req;
    logic ev_valid;
    bwm_ev_s ev;
    logic [`BWM_TAG_COUNT-1:0] tag_monitored;
    wire logic req_ready;
    wire logic ev_ready;
    wire logic rsp_valid_q;
    wire logic [`BWM_DATA_W-1:0] rsp_data_q;
    int errors;
    int n_compared;
    int cycles;
    logic [`BWM_CNT_W-1:0] tot_m [`BWM_TAG_COUNT];
    logic [`BWM_CNT_W-1:0] miss_m [`BWM_TAG_COUNT];

    bwm_monitor_bank uut (
        .clk_sys(clk_sys),
        .rst(rst),
        .req_valid(req_valid),
        .req_ready(req_ready),
        .req(req),
        .rsp_valid_q(rsp_valid_q),
        .rsp_data_q(rsp_data_q),
        .ev_valid(ev_valid),
        .ev_ready(ev_ready),
        .ev(ev),
        .tag_monitored(tag_monitored)
    );

    always #5 clk_sys = ~clk_sys;

    // A hang anywhere ends the run through the same closing report.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [`BWM_ADDR_W-1:0] word_addr(input int tag, input logic miss);
        int off;
        int clump;
        off = miss ? int'(`BWM_MISS_OFFSET) : int'(`BWM_TOT_OFFSET);
        clump = miss ? `BWM_MISS_CLUMP : `BWM_TOT_CLUMP;
        // This layout is only trusted while the indexing version reads one.
        return `BWM_ADDR_W'((tag / clump) * `BWM_PAGE_BYTES + off
            + (tag % clump) * `BWM_WORD_BYTES);
    endfunction : word_addr

    function automatic logic [63:0] expect_word(input int tag, input logic miss);
        // Overflow stays clear: a 62-bit wrap is out of reach in simulation.
        return {~tag_monitored[tag], 1'b0, (miss ? miss_m[tag] : tot_m[tag])};
    endfunction : expect_word

    // The request is held until the edge that samples req_ready high.
    task automatic access(input logic wr, input logic [`BWM_ADDR_W-1:0] a,
                          output logic [63:0] d);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{write: wr, addr: a, wdata: 64'hA5A5_5A5A_FFFF_0000};
        repeat (60) begin
            #1;
            if (req_ready === 1'b1) break;
            @(posedge clk_sys);
        end
        @(posedge clk_sys);
        req_valid <= 1'b0;
        d = 64'hDEAD_BEEF_DEAD_BEEF;
        repeat (10) begin
            @(posedge clk_sys);
            #1;
            if (rsp_valid_q === 1'b1) begin
                d = rsp_data_q;
                break;
            end
        end
    endtask : access

    task automatic read_check(input int tag, input logic miss);
        logic [63:0] d;
        access(1'b0, word_addr(tag, miss), d);
        check(d, expect_word(tag, miss));
    endtask : read_check

    task automatic send_ev(input int tag, input logic [15:0] nbytes, input logic miss);
        @(posedge clk_sys);
        ev_valid <= 1'b1;
        ev <= '{tag: `BWM_TAG_W'(tag), bytes: nbytes, miss: miss};
        repeat (20) begin
            #1;
            if (ev_ready === 1'b1) break;
            @(posedge clk_sys);
        end
        @(posedge clk_sys);
        ev_valid <= 1'b0;
        tot_m[tag] = tot_m[tag] + `BWM_CNT_W'(nbytes);
        if (miss) begin
            miss_m[tag] = miss_m[tag] + `BWM_CNT_W'(nbytes);
        end
    endtask : send_ev

    // Every word of both kinds reads zero with the unavailable flag per tag.
    task automatic t_reset_values();
        for (int t = 0; t < `BWM_TAG_COUNT; t++) begin
            read_check(t, 1'b0);
            read_check(t, 1'b1);
        end
    endtask : t_reset_values

    // Misses land in both counters, hits only in the total one.
    task automatic t_counting();
        send_ev(0, 16'hFFFF, 1'b0);
        send_ev(0, 16'h0001, 1'b0);
        send_ev(31, 16'h1234, 1'b1);
        send_ev(17, 16'h0100, 1'b1);
        send_ev(17, 16'h0023, 1'b1);
        send_ev(16, 16'h0008, 1'b0);
        send_ev(15, 16'h0F00, 1'b1);
        foreach (tot_m[t]) begin
            if (tot_m[t] != '0) begin
                read_check(t, 1'b0);
                read_check(t, 1'b1);
                read_check(t, 1'b0);
            end
        end
    endtask : t_counting

    // Writes answer zero and leave the counts alone.
    task automatic t_writes_ignored();
        logic [63:0] d;
        access(1'b1, word_addr(17, 1'b0), d);
        check(d, 64'h0);
        access(1'b1, word_addr(31, 1'b1), d);
        check(d, 64'h0);
        read_check(17, 1'b0);
        read_check(31, 1'b1);
    endtask : t_writes_ignored

    // Offsets outside the two word ranges and unaligned offsets read zero.
    task automatic t_unmapped();
        logic [`BWM_ADDR_W-1:0] holes [6];
        logic [63:0] d;
        holes = '{13'h0004, 13'h0080, 13'h0880, 13'h0400, 13'h1FF8, 13'h1804};
        foreach (holes[i]) begin
            access(1'b0, holes[i], d);
            check(d, 64'h0);
        end
    endtask : t_unmapped

    // Dropping monitoring raises the unavailable flag at once on both words.
    task automatic t_unavailable();
        @(posedge clk_sys);
        tag_monitored <= ~tag_monitored;
        @(posedge clk_sys);
        for (int t = 0; t < `BWM_TAG_COUNT; t += 5) begin
            read_check(t, 1'b0);
            read_check(t, 1'b1);
        end
        read_check(17, 1'b1);
        read_check(31, 1'b0);
    endtask : t_unavailable

    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        ev_valid = 1'b0;
        ev = '0;
        tag_monitored = 32'hFFFF_0FF7;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        foreach (tot_m[t]) begin
            tot_m[t] = '0;
            miss_m[t] = '0;
        end
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_values();
        t_counting();
        t_writes_ignored();
        t_unmapped();
        t_unavailable();
        final_report();
    end
endmodule : tb_top
